// ---- dv/spi_peer_model.sv ----
// Purpose: external serial slave facing the port in master mode
// Assumes: clock edges far apart on the system clock scale
// Notes:   data line toggles once released, not held
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  input  wire logic       i_sck,
  input  wire logic       i_sel_n,
  input  wire logic       i_sdo,
  input  wire logic       i_idle,
  input  wire logic       i_msb,
  input  wire logic       i_lead,
  input  wire logic [7:0] i_tx,
  output var  logic       o_sdi,
  output var  logic [7:0] o_rx
);
  logic [7:0] sh_r;
  logic       skip_r;
  initial o_sdi = 1'b0;
  // First bit ready once select falls, before any clock
  always @(negedge i_sel_n) begin
    sh_r = i_tx;
    skip_r = !i_lead;
    o_sdi = i_msb ? sh_r[7] : sh_r[0];
  end
  // Released line must not keep its last value
  always @(posedge i_sel_n) o_sdi = ~o_sdi;
  // Trailing capture keeps the first bit over the first leading edge
  always @(i_sck) if (!i_sel_n) begin
    if ((i_sck != i_idle) == i_lead) begin
      o_rx = i_msb ? {o_rx[6:0], i_sdo} : {i_sdo, o_rx[7:1]};
    end else if (skip_r) begin
      skip_r = 1'b0;
    end else begin
      sh_r = i_msb ? sh_r << 1 : sh_r >> 1;
      o_sdi = i_msb ? sh_r[7] : sh_r[0];
    end
  end
endmodule // spi_peer_model
`default_nettype wire

// ---- dv/spi_port_checker.sv ----
// Purpose: port-level assertions for the SPI port
// Assumes: one clock, sync reset; master-mode traffic
// Notes:   bound to the design top after the module
`timescale 1ns/10ps
`default_nettype none
module spi_port_checker (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        o_sck,
  input wire logic        o_sck_oe,
  input wire logic        o_sdo_oe,
  input wire logic        o_sel_n,
  input wire logic        o_sel_n_oe,
  input wire logic        o_pins_en,
  input wire logic        o_done_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ********************
  // Helper logic
  // ********************
  logic [4:0] edges_r;
  wire        wr  = i_psel && i_pwrite;
  wire        dwr = wr && (i_paddr == 12'h008);
  // Counts clock edges seen while the word is active
  always_ff @(posedge i_clk)
    if (i_sys_rst || o_sel_n) edges_r <= 5'h00;
    else if ($changed(o_sck)) edges_r <= edges_r + 5'h01;
  pins_off_a: assert property (!o_pins_en |-> !o_sck_oe && !o_sdo_oe
    && !o_sel_n_oe) else $error("pins driven while disabled");
  sel_oe_a: assert property (o_sel_n_oe |-> o_sck_oe)
    else $error("select driven outside master");
  oe_write_a: assert property ($changed(o_sck_oe) |-> $past(wr)
    || $past(wr, 2) || $past(i_sys_rst)) else $error("clock enable moved");
  sck_quiet_a: assert property ($changed(o_sck) && o_sck_oe
    |-> !$past(o_sel_n) || !$past(o_sel_n, 2) || $past(wr) || $past(wr, 2))
    else $error("clock moved while idle");
  done_hold_a: assert property (o_done_irq && !i_psel && !$past(i_psel)
    |=> o_done_irq) else $error("done flag dropped by itself");
  en_change_a: assert property ($changed(o_pins_en) |-> $past(wr)
    || $past(wr, 2) || $past(i_sys_rst)) else $error("enable moved");
  start_sel_a: assert property ($fell(o_sel_n) |-> $past(dwr)
    || $past(dwr, 2)) else $error("transfer without data write");
  word_len_a: assert property ($rose(o_sel_n) |-> edges_r == 5'd15
    || edges_r == 5'd16) else $error("word is not eight periods");
  cover property ($rose(o_done_irq));
  cover property ($fell(o_sel_n));
  cover property ($fell(o_pins_en));
endmodule // spi_port_checker
bind spi_master_slave_port spi_port_checker chk (.*);
`default_nettype wire

// ---- dv/tb_spi_master_slave_port.sv ----
// Purpose: register-level test of the SPI port as master
// Assumes: APB master tasks; peer model acts as slave
// Notes:   slave-mode shifting is not exercised here
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_map.vh"
module tb_spi_master_slave_port;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [31:0] o_prdata, rd;
  logic        o_pready, o_pslverr, o_sck, o_sck_oe, o_sdo, o_sdo_oe, err;
  logic        o_sel_n, o_sel_n_oe, o_pins_en, o_done_irq, i_sdi;
  logic        idle = 1'b0;
  logic        msb = 1'b1;
  logic        lead = 1'b1;
  logic [7:0]  tx = 8'h96;
  logic [7:0]  rx;
  wire         i_ce = 1'b1;
  wire         i_sub_clk = 1'b0;
  wire         i_tmr_match = 1'b0;
  wire         i_sck = o_sck_oe ? o_sck : idle;
  wire         i_sel_n = o_sel_n_oe ? o_sel_n : 1'b1;
  int          fails = 0;
  int          compares = 0;
  spi_master_slave_port uut (.*);
  spi_peer_model peer (.i_sck(o_sck), .i_sel_n(o_sel_n), .i_sdo(o_sdo),
    .i_idle(idle), .i_msb(msb), .i_lead(lead), .i_tx(tx), .o_sdi(i_sdi),
    .o_rx(rx));
  always #25 i_clk = ~i_clk;
  // ********************
  // Tasks
  // ********************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    apb(1'b0, `OFF_MODE_CTRL, 32'h0);
    chk(rd, 32'he0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, `OFF_MODE_CTRL, 32'h0);
    apb(1'b1, `OFF_PIN_FLAG_CTRL, 32'h3c);
    chk({o_pins_en, o_sck_oe, o_sel_n_oe}, 32'h0);
    apb(1'b1, `OFF_MODE_CTRL, 32'h02);
    repeat (2) @(posedge i_clk);
    chk({o_pins_en, o_sck_oe, o_sel_n_oe, o_sck}, 32'he);
    apb(1'b1, `OFF_SHIFT_DATA, 32'ha5);
    apb(1'b0, `OFF_PIN_FLAG_CTRL, 32'h0);
    chk(rd, 32'h3c);
    apb(1'b1, `OFF_SHIFT_DATA, 32'h3c);
    apb(1'b0, `OFF_PIN_FLAG_CTRL, 32'h0);
    chk(rd, 32'h3e);
    while (o_done_irq !== 1'b1) @(posedge i_clk);
    chk(rx, 32'ha5);
    apb(1'b0, `OFF_SHIFT_DATA, 32'h0);
    chk(rd, 32'h96);
    apb(1'b0, `OFF_PIN_FLAG_CTRL, 32'h0);
    chk(rd, 32'h3f);
    apb(1'b1, `OFF_PIN_FLAG_CTRL, 32'h3e);
    apb(1'b0, `OFF_PIN_FLAG_CTRL, 32'h0);
    chk(rd, 32'h3e);
    idle <= 1'b1;
    msb <= 1'b0;
    tx <= 8'h4d;
    apb(1'b1, `OFF_PIN_FLAG_CTRL, 32'h14);
    repeat (2) @(posedge i_clk);
    chk({o_done_irq, o_sck}, 32'h1);
    apb(1'b1, `OFF_SHIFT_DATA, 32'h6b);
    while (o_done_irq !== 1'b1) @(posedge i_clk);
    chk(rx, 32'h6b);
    apb(1'b0, `OFF_SHIFT_DATA, 32'h0);
    chk(rd, 32'h4d);
    idle <= 1'b0;
    lead <= 1'b0;
    msb <= 1'b1;
    tx <= 8'h5a;
    apb(1'b1, `OFF_MODE_CTRL, 32'h22);
    apb(1'b1, `OFF_PIN_FLAG_CTRL, 32'h2c);
    apb(1'b1, `OFF_SHIFT_DATA, 32'hc3);
    while (o_done_irq !== 1'b1) @(posedge i_clk);
    chk(rx, 32'hc3);
    apb(1'b0, `OFF_SHIFT_DATA, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b1, `OFF_PIN_FLAG_CTRL, 32'h10);
    repeat (2) @(posedge i_clk);
    chk({o_sck_oe, o_sel_n_oe}, 32'h2);
    apb(1'b1, `OFF_MODE_CTRL, 32'ha2);
    repeat (2) @(posedge i_clk);
    chk({o_pins_en, o_sck_oe, o_sel_n_oe}, 32'h4);
    apb(1'b1, `OFF_MODE_CTRL, 32'ha0);
    repeat (2) @(posedge i_clk);
    chk({o_pins_en, o_sck_oe, o_sdo_oe, o_sel_n_oe}, 32'h0);
    end_of_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    end_of_test;
  end
endmodule // tb_spi_master_slave_port
`default_nettype wire

// ---- rtl/spi_edge_tick.v ----
// Purpose: one-cycle pulse on a selected edge of a sampled level
// Assumes: input already synchronous to i_clk
// Notes:   used for the sub clock and timer match tick
`timescale 1ns/10ps
`default_nettype none
module spi_edge_tick (
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_ce,
  input  wire i_lvl,
  input  wire i_rise,
  output wire o_tick
);
  reg lvl_r;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      lvl_r <= 1'b0;
    end else if (i_ce) begin
      lvl_r <= i_lvl;
    end
  end
  assign o_tick = i_ce & (i_rise ? (i_lvl & ~lvl_r) : (~i_lvl & lvl_r));
endmodule // spi_edge_tick
`default_nettype wire

// ---- rtl/spi_master_slave_port.v ----
// Purpose: four-wire serial port, master or slave, APB register access
// Assumes: pins synchronous to i_clk; slave clock well below i_clk/4
// Notes:   I2C, time-out and debounce are not built
// Summary of operation
// - Select enable low floats select pin; high drives or uses it
// - Data write during a transfer is dropped and sets collision flag
// - Collision flag is sticky; only software clears it
// - Transfer done flag set at completion, sticky until cleared
// - Master mode: data write starts send and receive together
// - Slave mode: external clock shifts data out and in
// - Slave output bit ready per polarity and edge settings
// - Port keeps running in idle while its clock source runs
// - Interface enable low releases all four pins
// - Enabled master idles clock at the inverse of the polarity bit; data input floats
// - Enabled slave never drives the clock line
// - Master makes the clock; slave takes it only from master
// - Bits collect in shift buffer, copied to data register at end
// - Three-bit mode field picks divider, sub clock, timer, or slave
// - Order bit high sends MSB first, low LSB first
// - Polarity high idles clock low; edge bit picks capture edge
// - One eight-bit data register holds transmit and receive byte
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_map.vh"
module spi_master_slave_port (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_ce,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_sub_clk,
  input  wire        i_tmr_match,
  input  wire        i_sck,
  output reg         o_sck,
  output reg         o_sck_oe,
  input  wire        i_sdi,
  output reg         o_sdo,
  output reg         o_sdo_oe,
  input  wire        i_sel_n,
  output reg         o_sel_n,
  output reg         o_sel_n_oe,
  output reg         o_pins_en,
  output reg         o_done_irq
);

  // ********************
  // Registers
  // ********************
  reg  [7:0] mode_r;
  reg  [7:0] pf_r;
  reg  [7:0] data_r;
  reg  [7:0] shift_r;
  reg  [3:0] bits_r;
  reg        busy_r;
  reg  [5:0] div_r;
  reg        phase_r;
  reg        sck_in_r;
  reg        tmr_half_r;

  wire [2:0] mode     = mode_r[`MODE_SEL_HI:`MODE_SEL_LO];
  wire       en       = mode_r[`MODE_IF_EN];
  wire       pol      = pf_r[`PF_POL];
  wire       edge_sel = pf_r[`PF_EDGE];
  wire       msb      = pf_r[`PF_ORDER];
  wire       sel_en   = pf_r[`PF_SEL_EN];
  wire       slave    = (mode == `MODE_SLAVE);
  wire       master   = (mode < `MODE_SLAVE);
  wire       idle_lvl = ~pol;
  // Capture on rising when polarity and edge bits agree
  wire       cap_rise = (pol == edge_sel);

  // ********************
  // APB decode
  // ********************
  wire acc  = i_psel & i_penable & ~o_pready;
  wire wr   = acc & i_pwrite;
  wire hit_m = (i_paddr == `OFF_MODE_CTRL);
  wire hit_p = (i_paddr == `OFF_PIN_FLAG_CTRL);
  wire hit_d = (i_paddr == `OFF_SHIFT_DATA);
  wire wr_d = wr & hit_d;
  wire wr_p = wr & hit_p;

  // ********************
  // Master bit-rate ticks
  // ********************
  wire sub_tick;
  wire tmr_tick;
  spi_edge_tick u_sub (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_lvl     (i_sub_clk),
    .i_rise    (1'b1),
    .o_tick    (sub_tick)
  );
  spi_edge_tick u_tmr (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_lvl     (i_tmr_match),
    .i_rise    (1'b1),
    .o_tick    (tmr_tick)
  );

  reg [5:0] half_lim;
  always @* begin
    case (mode)
      `MODE_DIV4:  half_lim = `HALF_DIV4;
      `MODE_DIV16: half_lim = `HALF_DIV16;
      `MODE_DIV64: half_lim = `HALF_DIV64;
      default:     half_lim = 6'h00;
    endcase
  end

  reg half_tick;
  always @* begin
    case (mode)
      `MODE_DIV4,
      `MODE_DIV16,
      `MODE_DIV64: half_tick = (div_r == half_lim);
      `MODE_SUB:   half_tick = sub_tick;
      `MODE_TMR:   half_tick = tmr_tick & tmr_half_r;
      default:     half_tick = 1'b0;
    endcase
  end

  // ********************
  // Slave clock edges
  // ********************
  // Inputs are synchronous, so one stage gives the edge history
  wire sck_rise = i_sck & ~sck_in_r;
  wire sck_fall = ~i_sck & sck_in_r;
  wire s_cap    = cap_rise ? sck_rise : sck_fall;
  wire sel_act  = ~sel_en | ~i_sel_n;

  wire last_bit = (bits_r == `BITS_PER_WORD - 4'h1);
  wire in_bit   = i_sdi;
  wire [7:0] cap_val = msb ? {shift_r[6:0], in_bit} : {in_bit, shift_r[7:1]};

  // Phase 0 ends on the leading edge; edge bit high captures there
  wire m_step   = busy_r & master & half_tick;
  wire m_cap    = m_step & (edge_sel ? ~phase_r : phase_r);
  wire do_cap   = master ? m_cap : (en & slave & sel_act & s_cap);
  wire done_evt = busy_r & do_cap & last_bit;
  wire start_ok = wr_d & en & ~busy_r;
  wire coll_evt = wr_d & busy_r;

  // ********************
  // Transfer engine
  // ********************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_r     <= 1'b0;
      bits_r     <= 4'h0;
      shift_r    <= 8'h00;
      data_r     <= 8'h00;
      div_r      <= 6'h00;
      phase_r    <= 1'b0;
      sck_in_r   <= 1'b0;
      tmr_half_r <= 1'b0;
    end else if (i_ce) begin
      sck_in_r <= i_sck;
      if (tmr_tick) begin
        tmr_half_r <= ~tmr_half_r;
      end
      if (busy_r & master) begin
        div_r <= half_tick ? 6'h00 : div_r + 6'h01;
      end else begin
        div_r <= 6'h00;
      end
      if (m_step) begin
        phase_r <= ~phase_r;
      end
      if (!en) begin
        busy_r  <= 1'b0;
        phase_r <= 1'b0;
        bits_r  <= 4'h0;
      end else if (start_ok) begin
        // Data word goes straight into the shift buffer
        shift_r <= i_pwdata[7:0];
        data_r  <= i_pwdata[7:0];
        busy_r  <= master;
        bits_r  <= 4'h0;
        phase_r <= 1'b0;
      end else begin
        if (do_cap) begin
          shift_r <= cap_val;
          busy_r  <= ~last_bit;
          bits_r  <= last_bit ? 4'h0 : bits_r + 4'h1;
          if (last_bit) begin
            data_r <= cap_val;
          end
        end
        if (slave & s_cap & sel_act & ~last_bit) begin
          busy_r <= 1'b1;
        end
        if (slave & sel_en & i_sel_n) begin
          // Deselect aborts a partial slave word
          busy_r <= 1'b0;
          bits_r <= 4'h0;
        end
      end
    end
  end

  // ********************
  // Registers and flags
  // ********************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_r <= `MODE_CTRL_RST;
      pf_r   <= `PIN_FLAG_RST;
    end else if (i_ce) begin
      if (wr & hit_m) begin
        mode_r <= i_pwdata[7:0] & `MODE_CTRL_WMASK;
      end
      if (wr_p) begin
        pf_r[5:2] <= i_pwdata[5:2];
      end
      // Set wins over a same-cycle software clear
      pf_r[`PF_WRITE_COLLISION_FLAG] <= coll_evt |
        (pf_r[`PF_WRITE_COLLISION_FLAG] & ~(wr_p & ~i_pwdata[`PF_WRITE_COLLISION_FLAG]));
      pf_r[`PF_DONE] <= done_evt |
        (pf_r[`PF_DONE] & ~(wr_p & ~i_pwdata[`PF_DONE]));
    end
  end

  // ********************
  // APB slave
  // ********************
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else if (i_ce) begin
      o_pready  <= acc;
      o_pslverr <= acc & ~(hit_m | hit_p | hit_d);
      if (acc & ~i_pwrite) begin
        case (1'b1)
          hit_m:   o_prdata <= {24'h000000, mode_r};
          hit_p:   o_prdata <= {24'h000000, pf_r};
          hit_d:   o_prdata <= {24'h000000, data_r};
          default: o_prdata <= 32'h00000000;
        endcase
      end else begin
        o_prdata <= 32'h00000000;
      end
    end
  end

  // ********************
  // Pins
  // ********************
  // Outgoing bit per order; slave sets it up before first edge
  wire out_bit = msb ? shift_r[7] : shift_r[0];
  reg sck_nxt;
  always @* begin
    sck_nxt = idle_lvl;
    if (busy_r & master) begin
      // Trailing half of each period shows the active level
      sck_nxt = (phase_r ^ m_step) ? ~idle_lvl : idle_lvl;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sck      <= 1'b1;
      o_sck_oe   <= 1'b0;
      o_sdo      <= 1'b0;
      o_sdo_oe   <= 1'b0;
      o_sel_n    <= 1'b1;
      o_sel_n_oe <= 1'b0;
      o_pins_en  <= 1'b0;
      o_done_irq <= 1'b0;
    end else if (i_ce) begin
      o_pins_en  <= en;
      o_sck      <= sck_nxt;
      o_sck_oe   <= en & master;
      o_sdo      <= out_bit;
      o_sdo_oe   <= en & (master | (sel_act & ~(sel_en & i_sel_n)));
      o_sel_n    <= ~(master & (busy_r | start_ok));
      o_sel_n_oe <= en & master & sel_en;
      o_done_irq <= pf_r[`PF_DONE] | done_evt;
    end
  end

endmodule // spi_master_slave_port
`default_nettype wire

// ---- rtl/spi_port_map.vh ----
// Purpose: register offsets, field positions, reset values for the SPI port
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes:   definitions only
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// ********************
// Register offsets
// ********************
`define OFF_MODE_CTRL      12'h000
`define OFF_PIN_FLAG_CTRL  12'h004
`define OFF_SHIFT_DATA     12'h008

// ********************
// Mode control fields
// ********************
`define MODE_SEL_HI        7
`define MODE_SEL_LO        5
`define MODE_IF_EN         1
`define MODE_CTRL_RST      8'he0
`define MODE_CTRL_WMASK    8'he2

// ********************
// Pin and flag control fields
// ********************
`define PF_POL             5
`define PF_EDGE            4
`define PF_ORDER           3
`define PF_SEL_EN          2
`define PF_WRITE_COLLISION_FLAG            1
`define PF_DONE            0
`define PIN_FLAG_RST       8'h00

// ********************
// Mode codes
// ********************
`define MODE_DIV4          3'h0
`define MODE_DIV16         3'h1
`define MODE_DIV64         3'h2
`define MODE_SUB           3'h3
`define MODE_TMR           3'h4
`define MODE_SLAVE         3'h5

// ********************
// Half-period counts in system clocks, less one; word length in bits
// ********************
`define HALF_DIV4          6'h01
`define HALF_DIV16         6'h07
`define HALF_DIV64         6'h1f
`define BITS_PER_WORD      4'h8

`endif
